// File: pm_pkg.sv
// Notes on behaviour
// - Lane data path is 8 bits at Gen1/Gen2 and 32 bits at Gen3.
// - Each lane drives a control flag beside its transmit data byte.
// - Transmit data valid is high only while the data bus holds valid data.
// - At Gen3 the first transfer of each block is flagged by block start, both ways.
// - Detect request tells the PHY to start receiver detection or loopback.
// - Transmit electrical idle holds the PHY transmitter in electrical idle.
// - In compliance mode the compliance output forces negative running disparity.
// - Receive invert request makes the PHY invert its receive decoding polarity.
// - Two-bit power request selects fully on, standby, low power or off.
// - Gen3 coefficient word: pre-cursor 5:0, main 11:6, post-cursor 17:12.
// - De-emphasis is fixed: -6 dB at Gen2, -3.5 dB at Gen1.
// - Gen3 sync header: 2'b01 ordered set block, 2'b10 data block, both ways.
// - Link rate code: 2'b00 Gen1, 2'b01 Gen2, 2'b1x Gen3.
// - Training state is a five-bit code; detect quiet 0, active link 5'b01111.
// - At Gen3 skip low means ignore transmit data this cycle; high means valid.
// - Idle inference select: 3'b0xx none, 3'b100..3'b111 pick an inference window.
// - Test bit 5 set blocks compliance; toggling it enters and leaves compliance.
// - Negotiated lane count is reported one-hot on four bits after training.
//
// Purpose: Shared constants of the PIPE MAC-side lane block.
// Assumes: AHB-Lite register access, 32-bit words, eight lanes.
// Notes: Offsets are byte addresses within the slave window.
package pm_pkg;
	localparam int LANES = 8;
	localparam int DW = 32;
	localparam int RXW = 44;
	// ****************************************
	// Register offsets.
	// ****************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TXDATA = 8'h04;
	localparam logic [7:0] A_TXCTL = 8'h08;
	localparam logic [7:0] A_COEF = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_RXDATA = 8'h14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0084;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// ****************************************
	// Control field positions.
	// ****************************************
	localparam int C_RATE = 0;
	localparam int C_IDLE = 2;
	localparam int C_DET = 3;
	localparam int C_COMPL = 4;
	localparam int C_INV = 5;
	localparam int C_PWR = 6;
	localparam int C_INFER = 8;
	localparam int C_TRAIN = 11;
	localparam int C_WIDTH = 16;
	localparam int T_BLK = 4;
	localparam int T_SYNC = 5;
	localparam int T_SKIP = 6;
	localparam int S_DONE = 1;
	// ****************************************
	// Receive bundle layout.
	// ****************************************
	localparam int RB_K = 32;
	localparam int RB_BLK = 36;
	localparam int RB_SYNC = 37;
	localparam int RB_LOCK = 39;
	localparam int RB_DONE = 40;
	localparam int RB_STAT = 41;
	// ****************************************
	// Codes.
	// ****************************************
	localparam logic [1:0] SH_ORDERED = 2'h1;
	localparam logic [1:0] SH_DATA = 2'h2;
	localparam logic [1:0] RATE_G1 = 2'h0;
	localparam logic [1:0] RATE_G2 = 2'h1;
	localparam logic DEEMPH_3P5DB = 1'b1;
	localparam logic DEEMPH_6DB = 1'b0;
	localparam logic [3:0] ONE_LANE = 4'h1;
	typedef enum logic [4:0] {
		ST_DET_QUIET = 5'h00,
		ST_POLL_ACTIVE = 5'h02,
		ST_POLL_COMPL = 5'h03,
		ST_L0 = 5'h0f,
		ST_EQ_DONE = 5'h1f
	} pm_train_e;
endpackage

// File: pm_lane_if.sv
// Purpose: Broadcast transmit command from the register side to every lane.
// Assumes: All lanes run on hclk.
// Notes: edge marks a sampled rising edge of the interface clock.
`timescale 1ns/1ps
`default_nettype none
interface pm_lane_if;
	logic edge_ev;
	logic send;
	logic gen3;
	logic [31:0] word;
	logic [3:0] flags;
	logic blk;
	logic [1:0] sync_hdr;
	logic skip_req;
	modport ctl (output edge_ev, send, gen3, word, flags, blk, sync_hdr, skip_req);
	modport lane (input edge_ev, send, gen3, word, flags, blk, sync_hdr, skip_req);
endinterface
`default_nettype wire

// File: pm_lane.sv
// Purpose: One PIPE lane: registered transmit outputs, synchronised receive capture.
// Assumes: Receive pins are asynchronous to hclk.
// Notes: Transmit outputs and receive capture move on the sampled interface clock edge; the synchroniser stages move every hclk.
`timescale 1ns/1ps
`default_nettype none
module pm_lane (
	input wire logic hclk,
	input wire logic hresetn,
	pm_lane_if.lane lif,
	input wire logic [43:0] rx_bus,
	output logic [31:0] tx_data,
	output logic [3:0] tx_flag,
	output logic tx_valid,
	output logic tx_blk,
	output logic [1:0] tx_sync,
	output logic tx_skip,
	output logic [43:0] rx_cap
);
	logic [43:0] rx_s1_reg;
	logic [43:0] rx_s2_reg;

	// Two stages before anything looks at the receive pins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_s1_reg <= '0;
			rx_s2_reg <= '0;
		end else begin
			rx_s1_reg <= rx_bus;
			rx_s2_reg <= rx_s1_reg;
		end
	end

	// Receive side is captured once per interface clock edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_cap <= '0;
		end else if (lif.edge_ev) begin
			rx_cap <= rx_s2_reg;
		end
	end

	// Transmit word launch; narrow rates carry one byte and one flag.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_data <= '0;
			tx_flag <= '0;
			tx_valid <= 1'b0;
			tx_blk <= 1'b0;
			tx_sync <= '0;
			tx_skip <= 1'b1;
		end else if (lif.edge_ev) begin
			tx_valid <= lif.send;
			tx_data <= lif.gen3 ? lif.word : {24'h0, lif.word[7:0]};
			tx_flag <= lif.gen3 ? lif.flags : {3'h0, lif.flags[0]};
			tx_blk <= lif.gen3 & lif.send & lif.blk;
			tx_sync <= lif.gen3 ? lif.sync_hdr : 2'h0;
			tx_skip <= lif.gen3 ? (lif.send & ~lif.skip_req) : 1'b1;
		end
	end
endmodule // pm_lane
`default_nettype wire

// File: pm_pipe_mac.sv
// Purpose: MAC-side PIPE lane control with an AHB-Lite register slave.
// Assumes: hclk 40 MHz; interface clock sampled as an ordinary input.
// Notes: Zero-wait slave; a read right after a write sees the old value.
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module pm_pipe_mac (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pclk_in,
	input wire logic [31:0] test_in,
	output logic [255:0] tx_data,
	output logic [31:0] tx_control_flag,
	output logic [7:0] tx_word_valid,
	output logic [7:0] tx_block_start,
	output logic [15:0] tx_sync_header,
	output logic [7:0] tx_data_skip,
	output logic [7:0] receiver_detect_request,
	output logic [7:0] tx_elec_idle,
	output logic [7:0] compliance_disparity_force,
	output logic [7:0] rx_invert_request,
	output logic [15:0] power_state_request,
	output logic [17:0] tx_equalizer_coefficients,
	output logic [2:0] rx_preset_select,
	output logic tx_deemph,
	output logic [1:0] link_rate,
	output logic [4:0] training_state_code,
	output logic [2:0] idle_inference_select,
	output logic [3:0] lane_active,
	input wire logic [255:0] rx_data,
	input wire logic [31:0] rx_ctl_flag,
	input wire logic [7:0] rx_block_start,
	input wire logic [15:0] rx_sync_header,
	input wire logic [7:0] rx_symbol_locked,
	input wire logic [7:0] phy_done_pulse,
	input wire logic [23:0] rx_status_code
);
	// ****************************************
	// Declarations.
	// ****************************************
	logic [2:0] pclk_sync_reg;
	logic [1:0] test_s1_reg;
	logic [1:0] test_s2_reg;
	logic test5_d_reg;
	logic test5_edge;
	logic addr_ph;
	logic wr_ph_reg;
	logic [7:0] wa_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] txdata_reg;
	logic [7:0] txctl_reg;
	logic [20:0] coef_reg;
	logic pend_reg;
	logic done_reg;
	logic cap_new_reg;
	logic done_any;
	logic [31:0] rd_next;
	logic [4:0] req_code;
	pm_pkg::pm_train_e state_reg;
	logic [43:0] rx_cap [pm_pkg::LANES];
	pm_lane_if lif ();

	// ****************************************
	// Clock and test input synchronisers.
	// ****************************************
	// The interface clock is sampled; its rising edge is the lane strobe.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pclk_sync_reg <= '0;
		end else begin
			pclk_sync_reg <= {pclk_sync_reg[1:0], pclk_in};
		end
	end

	// Only test bits 5 and 0 are used; the rest are the far side's duty.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			test_s1_reg <= '0;
			test_s2_reg <= '0;
			test5_d_reg <= 1'b0;
		end else begin
			test_s1_reg <= {test_in[5], test_in[0]};
			test_s2_reg <= test_s1_reg;
			test5_d_reg <= test_s2_reg[1];
		end
	end

	assign test5_edge = test_s2_reg[1] ^ test5_d_reg;

	// ****************************************
	// AHB-Lite slave.
	// ****************************************
	// Only whole-word transfers are taken; anything else is ignored.
	assign addr_ph = hsel & hready & htrans[1] & (hsize == pm_pkg::HSIZE_WORD);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_reg <= 1'b0;
			wa_reg <= '0;
		end else begin
			wr_ph_reg <= addr_ph & hwrite;
			wa_reg <= haddr[7:0];
		end
	end

	// Read data is picked in the address phase so it leaves a flip-flop.
	always_comb begin
		rd_next = '0;
		case (haddr[7:0])
			pm_pkg::A_CTRL: rd_next = ctrl_reg;
			pm_pkg::A_TXDATA: rd_next = txdata_reg;
			pm_pkg::A_TXCTL: rd_next = {24'h0, txctl_reg};
			pm_pkg::A_COEF: rd_next = {11'h0, coef_reg};
			pm_pkg::A_STATUS: rd_next = {8'h0, rx_cap[0][pm_pkg::RB_K +: 4], lane_active,
				test_s2_reg, state_reg, pend_reg, rx_cap[0][pm_pkg::RB_SYNC +: 2],
				rx_cap[0][pm_pkg::RB_BLK], rx_cap[0][pm_pkg::RB_STAT +: 3], done_reg,
				rx_cap[0][pm_pkg::RB_LOCK]};
			pm_pkg::A_RXDATA: rd_next = rx_cap[0][31:0];
			default: rd_next = '0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hrdata <= (addr_ph & ~hwrite) ? rd_next : 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Plain control registers written in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= pm_pkg::CTRL_RST;
			txdata_reg <= '0;
			txctl_reg <= '0;
			coef_reg <= '0;
		end else if (wr_ph_reg) begin
			if (wa_reg == pm_pkg::A_CTRL) begin
				ctrl_reg <= hwdata;
			end
			if (wa_reg == pm_pkg::A_TXDATA) begin
				txdata_reg <= hwdata;
			end
			if (wa_reg == pm_pkg::A_TXCTL) begin
				txctl_reg <= hwdata[7:0];
			end
			if (wa_reg == pm_pkg::A_COEF) begin
				coef_reg <= hwdata[20:0];
			end
		end
	end

	// A word write arms one launch; a new write in the launch cycle wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 1'b0;
		end else if (wr_ph_reg && wa_reg == pm_pkg::A_TXDATA) begin
			pend_reg <= 1'b1;
		end else if (lif.edge_ev) begin
			pend_reg <= 1'b0;
		end
	end

	// ****************************************
	// PHY completion flag.
	// ****************************************
	always_comb begin
		done_any = 1'b0;
		for (int i = 0; i < pm_pkg::LANES; i++) begin
			done_any = done_any | rx_cap[i][pm_pkg::RB_DONE];
		end
	end

	// Sticky done, write one to clear; a fresh pulse beats the clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_new_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cap_new_reg <= lif.edge_ev;
			if (cap_new_reg && done_any) begin
				done_reg <= 1'b1;
			end else if (wr_ph_reg && wa_reg == pm_pkg::A_STATUS && hwdata[pm_pkg::S_DONE]) begin
				done_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Training state.
	// ****************************************
	assign req_code = hwdata[pm_pkg::C_TRAIN +: 5];

	// Software steers the state; test bit 5 gates and toggles compliance.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= pm_pkg::ST_DET_QUIET;
		end else if (wr_ph_reg && wa_reg == pm_pkg::A_CTRL) begin
			if (req_code == pm_pkg::ST_POLL_COMPL && test_s2_reg[1]) begin
				state_reg <= pm_pkg::ST_POLL_ACTIVE;
			end else begin
				state_reg <= pm_pkg::pm_train_e'(req_code);
			end
		end else if (test5_edge) begin
			case (state_reg)
				pm_pkg::ST_POLL_COMPL: begin
					state_reg <= pm_pkg::ST_POLL_ACTIVE;
				end
				pm_pkg::ST_POLL_ACTIVE: begin
					if (!test_s2_reg[1]) begin
						state_reg <= pm_pkg::ST_POLL_COMPL;
					end
				end
				default: begin
					state_reg <= state_reg;
				end
			endcase
		end
	end

	// ****************************************
	// Per-lane and link control outputs.
	// ****************************************
	// All control pins leave flip-flops, one cycle behind the registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_rate <= pm_pkg::RATE_G1;
			tx_deemph <= pm_pkg::DEEMPH_3P5DB;
			receiver_detect_request <= '0;
			tx_elec_idle <= '1;
			compliance_disparity_force <= '0;
			rx_invert_request <= '0;
			power_state_request <= {pm_pkg::LANES{2'h2}};
			idle_inference_select <= '0;
			tx_equalizer_coefficients <= '0;
			rx_preset_select <= '0;
			training_state_code <= pm_pkg::ST_DET_QUIET;
			lane_active <= '0;
		end else begin
			link_rate <= ctrl_reg[pm_pkg::C_RATE +: 2];
			tx_deemph <= (ctrl_reg[pm_pkg::C_RATE +: 2] == pm_pkg::RATE_G2) ?
				pm_pkg::DEEMPH_6DB : pm_pkg::DEEMPH_3P5DB;
			receiver_detect_request <= {pm_pkg::LANES{ctrl_reg[pm_pkg::C_DET]}};
			tx_elec_idle <= {pm_pkg::LANES{ctrl_reg[pm_pkg::C_IDLE]}};
			compliance_disparity_force <= {pm_pkg::LANES{ctrl_reg[pm_pkg::C_COMPL] &
				(state_reg == pm_pkg::ST_POLL_COMPL)}};
			rx_invert_request <= {pm_pkg::LANES{ctrl_reg[pm_pkg::C_INV]}};
			power_state_request <= {pm_pkg::LANES{ctrl_reg[pm_pkg::C_PWR +: 2]}};
			idle_inference_select <= ctrl_reg[pm_pkg::C_INFER +: 3];
			tx_equalizer_coefficients <= coef_reg[17:0];
			rx_preset_select <= coef_reg[20:18];
			training_state_code <= state_reg;
			lane_active <= (state_reg == pm_pkg::ST_L0) ?
				(pm_pkg::ONE_LANE << ctrl_reg[pm_pkg::C_WIDTH +: 2]) : 4'h0;
		end
	end

	// ****************************************
	// Lanes.
	// ****************************************
	assign lif.edge_ev = pclk_sync_reg[1] & ~pclk_sync_reg[2];
	assign lif.send = pend_reg;
	assign lif.gen3 = ctrl_reg[pm_pkg::C_RATE + 1];
	assign lif.word = txdata_reg;
	assign lif.flags = txctl_reg[3:0];
	assign lif.blk = txctl_reg[pm_pkg::T_BLK];
	assign lif.sync_hdr = txctl_reg[pm_pkg::T_SYNC] ? pm_pkg::SH_DATA : pm_pkg::SH_ORDERED;
	assign lif.skip_req = txctl_reg[pm_pkg::T_SKIP];

	for (genvar g = 0; g < pm_pkg::LANES; g++) begin : g_lane
		pm_lane u_lane (
			.hclk(hclk),
			.hresetn(hresetn),
			.lif(lif),
			.rx_bus({rx_status_code[g*3 +: 3], phy_done_pulse[g], rx_symbol_locked[g],
				rx_sync_header[g*2 +: 2], rx_block_start[g], rx_ctl_flag[g*4 +: 4],
				rx_data[g*32 +: 32]}),
			.tx_data(tx_data[g*32 +: 32]),
			.tx_flag(tx_control_flag[g*4 +: 4]),
			.tx_valid(tx_word_valid[g]),
			.tx_blk(tx_block_start[g]),
			.tx_sync(tx_sync_header[g*2 +: 2]),
			.tx_skip(tx_data_skip[g]),
			.rx_cap(rx_cap[g])
		);
	end

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_launch;
		pend_reg && lif.edge_ev;
	endsequence

	sequence s_blocked;
		test_s2_reg[1] && state_reg != pm_pkg::ST_POLL_COMPL;
	endsequence

	chk_deemph_rate: assert property (
		(link_rate == pm_pkg::RATE_G2 |-> tx_deemph == pm_pkg::DEEMPH_6DB) and
		(link_rate == pm_pkg::RATE_G1 |-> tx_deemph == pm_pkg::DEEMPH_3P5DB))
		else $error("de-emphasis does not match rate");

	chk_lane_onehot: assert property (
		$onehot0(lane_active) &&
		(training_state_code != pm_pkg::ST_L0 -> lane_active == 4'h0))
		else $error("lane count not one-hot or shown before active link");

	chk_no_compliance: assert property (s_blocked |=>
		state_reg != pm_pkg::ST_POLL_COMPL)
		else $error("compliance entered while test bit 5 set");

	chk_narrow_width: assert property (
		tx_word_valid[0] && !lif.gen3 && $past(!lif.gen3) |-> tx_data[31:8] == 24'h0)
		else $error("upper lane bytes driven at narrow rate");

	// Lanes pick up a rate change only at the next interface edge, so skip is checked after one.
	chk_skip_narrow: assert property (
		lif.edge_ev && !lif.gen3 |=> tx_data_skip == 8'hff)
		else $error("skip driven low outside Gen3");

	chk_sync_code: assert property (tx_block_start[0] |->
		tx_sync_header[1:0] == pm_pkg::SH_ORDERED || tx_sync_header[1:0] == pm_pkg::SH_DATA)
		else $error("bad sync header at block start");

	chk_valid_launch: assert property (s_launch |=> tx_word_valid[0] [*3])
		else $error("launched word not held valid");

	chk_valid_idle: assert property (lif.edge_ev && !pend_reg |=>
		!tx_word_valid[0] && !tx_block_start[0])
		else $error("valid raised with nothing pending");

	chk_compl_force: assert property (compliance_disparity_force[0] |->
		training_state_code == pm_pkg::ST_POLL_COMPL)
		else $error("compliance force outside compliance state");
endmodule // pm_pipe_mac
`default_nettype wire

// File: pm_phy_model.sv
// Purpose: Behavioural PHY on the far side of the PIPE lanes.
// Assumes: The interface clock runs free; every lane carries the same stream.
// Notes: Before lock the data lines carry the inverse word, never stale data.
`timescale 1ns/1ps
`default_nettype none
module pm_phy_model (
	input wire logic pclk_in,
	input wire logic hresetn,
	input wire logic [7:0] receiver_detect_request,
	input wire logic [15:0] power_state_request,
	input wire logic [31:0] word,
	input wire logic [1:0] sh,
	input wire logic blk,
	output logic [255:0] rx_data,
	output logic [31:0] rx_ctl_flag,
	output logic [7:0] rx_block_start,
	output logic [15:0] rx_sync_header,
	output logic [7:0] rx_symbol_locked,
	output logic [7:0] phy_done_pulse,
	output logic [23:0] rx_status_code
);
	logic [2:0] lock_cnt;
	logic det_d;
	logic [1:0] pwr_d;
	logic lk;
	logic ev;
	assign lk = lock_cnt == 3'h7;
	assign ev = (receiver_detect_request[0] & !det_d) | (power_state_request[1:0] != pwr_d);
	// Lock takes several edges, so early captures must not see a valid flag.
	always_ff @(posedge pclk_in or negedge hresetn) begin
		if (!hresetn) begin
			lock_cnt <= 3'h0;
			det_d <= 1'b0;
			pwr_d <= 2'b10;
			rx_data <= '0;
			rx_ctl_flag <= '0;
			rx_block_start <= '0;
			rx_sync_header <= '0;
			rx_symbol_locked <= '0;
			phy_done_pulse <= '0;
			rx_status_code <= '0;
		end else begin
			lock_cnt <= lock_cnt + {2'h0, !lk};
			det_d <= receiver_detect_request[0];
			pwr_d <= power_state_request[1:0];
			rx_data <= {8{lk ? word : ~word}};
			rx_ctl_flag <= {8{word[3:0]}};
			rx_block_start <= {8{blk & lk}};
			rx_sync_header <= {8{sh}};
			rx_symbol_locked <= {8{lk}};
			phy_done_pulse <= {8{ev}};
			rx_status_code <= {8{receiver_detect_request[0] ? 3'h3 : 3'h0}};
		end
	end
endmodule // pm_phy_model
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the PIPE MAC lane block.
// Assumes: Zero-wait AHB-Lite slave; interface clock of 200 ns.
// Notes: Reads and launched words are checked from queues by monitors.
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ****************************************
	// Signals and instances.
	// ****************************************
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pclk_in = 0, blk = 0, rph = 0;
	logic [1:0] htrans = 0, sh = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, test_in = 0, word = 0, hrdata, d;
	logic hready, hreadyout, hresp, tx_deemph;
	logic [255:0] tx_data, rx_data;
	logic [31:0] tx_control_flag, rx_ctl_flag;
	logic [7:0] tx_word_valid, tx_block_start, tx_data_skip, receiver_detect_request;
	logic [7:0] tx_elec_idle, compliance_disparity_force, rx_invert_request;
	logic [7:0] rx_block_start, rx_symbol_locked, phy_done_pulse;
	logic [15:0] tx_sync_header, power_state_request, rx_sync_header;
	logic [17:0] tx_equalizer_coefficients;
	logic [2:0] rx_preset_select, idle_inference_select;
	logic [1:0] link_rate;
	logic [4:0] training_state_code;
	logic [3:0] lane_active;
	logic [23:0] rx_status_code;
	logic [63:0] rq[$], tq[$];
	int n_errors = 0, n_compared = 0, i, hi = 0;
	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;
	// The link clock starts 37 ns off phase; its edges keep a fixed phase against hclk.
	initial begin
		#37;
		forever #100 pclk_in = ~pclk_in;
	end
	pm_pipe_mac uut (.*);
	pm_phy_model phy (.*);
	// ****************************************
	// Checking and bus tasks.
	// ****************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	task automatic tmo(input int k);
		if (k >= 80) begin
			chk(0, 1);
			conclude;
		end
	endtask
	task automatic rdy;
		int k;
		for (k = 0; k < 80; k++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				break;
		end
		tmo(k);
	endtask
	// One bus cycle between transfers keeps a read from seeing a stale write.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dd);
		@(posedge hclk);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'b10;
		rdy;
		htrans <= 2'b00;
		hwdata <= dd;
		rph <= !w;
		rdy;
		rph <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dd);
		ahb(1, a, dd);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		rq.push_back({e & m, m});
		ahb(0, a, 0);
	endtask
	task automatic send(input logic [1:0] rt, input logic [6:0] c);
		logic g;
		g = rt[1];
		d = $urandom;
		wr(8'h00, {30'h0, rt});
		wr(8'h08, {25'h0, c});
		tq.push_back({24'h0, g ? c[3:0] : {3'h0, c[0]}, g & c[4],
			g ? (c[5] ? 2'b10 : 2'b01) : 2'b00, g ? !c[6] : 1'b1,
			g ? d : {24'h0, d[7:0]}});
		wr(8'h04, d);
		for (i = 0; i < 80; i++) begin
			@(posedge hclk);
			if (tq.size() == 0 && tx_word_valid[0] === 1'b0)
				break;
		end
		tmo(i);
	endtask
	// Read data is compared at the edge that closes the data phase.
	always @(posedge hclk) begin : mon_rd
		logic [63:0] q;
		if (rph && hreadyout && rq.size() > 0) begin
			q = rq.pop_front();
			chk(hrdata & q[31:0], q[63:32]);
			chk(hresp, 1'b0);
		end
	end
	// A launched word is compared on its first cycle; its length on its fall.
	always @(posedge hclk) begin : mon_tx
		logic [63:0] q;
		if (tx_word_valid[0] === 1'b1 && hi == 0) begin
			if (tq.size() == 0)
				chk(0, 1);
			else begin
				q = tq.pop_front();
				chk(tx_data[31:0], q[31:0]);
				chk(tx_data[255:224], q[31:0]);
				chk({tx_control_flag[3:0], tx_block_start[0], tx_sync_header[1:0],
					tx_data_skip[0]}, q[39:32]);
			end
		end
		if (tx_word_valid[0] === 1'b0 && hi > 0)
			chk(hi >= 7 && hi <= 9, 1);
		hi <= tx_word_valid[0] === 1'b1 ? hi + 1 : 0;
	end
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		void'($urandom(32'hf62eafce));
		test_in = {26'h2, 1'b1, 4'b0100, 1'b1};
		repeat (5) @(posedge hclk);
		chk({tx_data_skip, tx_elec_idle, power_state_request}, 32'hffffaaaa);
		chk({tx_deemph, link_rate, training_state_code, lane_active, tx_word_valid}, 32'h80000);
		hresetn <= 1;
		rd(8'h00, 32'h84, 32'hffffffff);
		$display("test reset done");
		for (int k = 0; k < 8; k++) begin
			d = ($urandom & 32'h3_07ef) | 32'h7800;
			d[1:0] = k[1:0];
			d[7:6] = k[2:1];
			wr(8'h00, d);
			@(negedge hclk);
			@(negedge hclk);
			chk(link_rate, d[1:0]);
			chk(tx_elec_idle, {8{d[2]}});
			chk(receiver_detect_request, {8{d[3]}});
			chk(rx_invert_request, {8{d[5]}});
			chk(power_state_request, {8{d[7:6]}});
			chk(idle_inference_select, d[10:8]);
			chk(training_state_code, 5'h0f);
			chk(lane_active, 4'h1 << d[17:16]);
			chk(tx_deemph, d[1:0] != 2'b01);
			rd(8'h00, d, 32'h3ffff);
		end
		d = $urandom;
		wr(8'h0c, d);
		wr(8'h40, 32'hffffffff);
		@(negedge hclk);
		chk(tx_equalizer_coefficients, d[17:0]);
		chk(rx_preset_select, d[20:18]);
		rd(8'h0c, d, 32'h1fffff);
		rd(8'h40, 0, 32'hffffffff);
		$display("test control done");
		for (int k = 0; k < 6; k++) begin
			d[6:0] = 7'($urandom);
			d[6:5] = k[1:0];
			send(k < 2 ? k[1:0] : {1'b1, k[0]}, d[6:0]);
		end
		$display("test transmit done");
		word = $urandom;
		sh = 2'b10;
		blk = 1;
		wr(8'h10, 32'h2);
		repeat (3) @(posedge pclk_in);
		rd(8'h14, word, 32'hffffffff);
		rd(8'h10, {24'h0, 2'b10, 1'b1, 5'h01}, 32'hff);
		wr(8'h00, 32'h8);
		repeat (3) @(posedge pclk_in);
		rd(8'h10, 32'h0f, 32'h1f);
		wr(8'h10, 32'h2);
		wr(8'h00, 32'h0);
		repeat (3) @(posedge pclk_in);
		rd(8'h10, 32'h01, 32'h1f);
		$display("test receive done");
		wr(8'h00, 32'h1810);
		@(negedge hclk);
		@(negedge hclk);
		chk(training_state_code, 5'h02);
		chk(compliance_disparity_force, 8'h00);
		@(posedge hclk);
		test_in[5] <= 1'b0;
		for (i = 0; i < 80 && training_state_code !== 5'h03; i++)
			@(negedge hclk);
		tmo(i);
		chk(compliance_disparity_force, 8'hff);
		@(posedge hclk);
		test_in[5] <= 1'b1;
		for (i = 0; i < 80 && training_state_code !== 5'h02; i++)
			@(negedge hclk);
		tmo(i);
		chk(training_state_code, 5'h02);
		rd(8'h10, 32'hc000, 32'hc000);
		$display("test compliance done");
		conclude;
	end
endmodule // tb
`default_nettype wire
